// ==== core/slo_pkg.sv ====
// Constants shared by both ends of the low-side output serial link
// Operation
// - Eight-bit output register, bit n drives output n+1
// - Exactly eight bits per transfer, master clocks
// - Ignore clock and data while select high
// - Select rising after eight bits loads register
// - Master: select low, eight clocks, select high
// - Master keeps clock low while select high
// - Refresh at twice PWM rate, max 5 kHz
// - At top rate refresh every 100 us
// - Override high forces first output on
package slo_pkg;
    localparam int WORD_BITS = 8;
    localparam int COUNT_BITS = 4;
    localparam logic [COUNT_BITS-1:0] COUNT_ONE = 4'h1;
    localparam logic [COUNT_BITS-1:0] COUNT_WORD = 4'h8;
    localparam logic [COUNT_BITS-1:0] COUNT_MAX = 4'hF;
    localparam logic [WORD_BITS-1:0] OUTPUT_RESET = 8'h00;
    localparam int TALLY_BITS = 8;

    // Timing in ns, counts in clock cycles
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int T1_LEAD_NS = 10;
    localparam int T3_HIGH_NS = 60;
    localparam int T4_LOW_NS = 60;
    localparam int T5_TAIL_NS = 80;
    localparam int T8_GAP_NS = 170;
    localparam int LEAD_CYCLES = (T1_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int HIGH_CYCLES = (T3_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int LOW_CYCLES = (T4_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int TAIL_CYCLES = (T5_TAIL_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int GAP_CYCLES = (T8_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DEVICE_SETTLE_CYCLES = 4;
    localparam int HALF_CYCLES = (HIGH_CYCLES > LOW_CYCLES) ? HIGH_CYCLES : LOW_CYCLES;
    localparam int PWM_MAX_HZ = 5000;
    localparam int REFRESH_PERIOD_US = 100;
    localparam int REFRESH_CYCLES = REFRESH_PERIOD_US * 1000 / CLOCK_PERIOD_NS;
    localparam int TIMER_BITS = 12;

    // Host register map, byte addresses
    localparam int ADDR_BITS = 4;
    localparam logic [ADDR_BITS-1:0] ADDR_DATA = 4'h0;
    localparam logic [ADDR_BITS-1:0] ADDR_CTRL = 4'h4;
    localparam logic [ADDR_BITS-1:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_REFRESH_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_PENDING_BIT = 1;
    localparam int STATUS_TALLY_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEAD = 3'b001,
        ST_HIGH = 3'b010,
        ST_LOW = 3'b011,
        ST_TAIL = 3'b100,
        ST_GAP = 3'b101
    } slo_state_type;
endpackage : slo_pkg

// ==== core/slo_link_if.sv ====
// Serial link wires between controller and output device
`timescale 1ns/1ps
interface slo_link_if;
    logic sclk;
    logic chipSelectLow;
    logic mosi;
    modport device(
        input sclk,
        input chipSelectLow,
        input mosi
    );
    modport host(
        output sclk,
        output chipSelectLow,
        output mosi
    );
endinterface : slo_link_if

// ==== core/slo_device.sv ====
// Serial output device: shift register, output control register, drivers
`timescale 1ns/1ps
module slo_device (
    slo_link_if.device link,
    input wire logic clock,
    input wire logic resetn,
    input wire logic firstOutputOverrideInput,
    output logic [slo_pkg::WORD_BITS-1:0] lowSideDriverOutput,
    output logic [slo_pkg::WORD_BITS-1:0] outputSwitchControl,
    output logic wordLoaded,
    output logic wordDiscarded,
    output logic [slo_pkg::TALLY_BITS-1:0] loadedTally,
    output logic [slo_pkg::TALLY_BITS-1:0] discardedTally
);
    import slo_pkg::*;

    // Link side state
    logic linkClear;
    logic inFrame;
    logic [COUNT_BITS-1:0] edgeCount;
    logic [WORD_BITS-1:0] shiftWord;

    // Clock side state
    logic csSync1;
    logic csSync2;
    logic csPrev;
    logic frameEnd;
    logic wordGood;
    logic overrideSync1;
    logic overrideSync2;
    logic [WORD_BITS-1:0] next_lowSideDriverOutput;

    // Clear for link logic, held while reset is low
    always_ff @(posedge clock) begin
        linkClear <= !resetn;
    end

    // Frame marker, dropped at once by select high
    always_ff @(posedge link.sclk or posedge link.chipSelectLow) begin
        if (link.chipSelectLow) begin
            inFrame <= 1'b0;
        end else begin
            inFrame <= 1'b1;
        end
    end

    // Rising edge count within a frame
    always_ff @(posedge link.sclk or posedge linkClear) begin
        if (linkClear) begin
            edgeCount <= '0;
        end else if (!link.chipSelectLow) begin
            if (!inFrame) begin
                edgeCount <= COUNT_ONE;
            end else if (edgeCount != COUNT_MAX) begin
                edgeCount <= edgeCount + COUNT_ONE;
            end
        end
    end

    // Shift in, first bit ends up most significant
    always_ff @(posedge link.sclk or posedge linkClear) begin
        if (linkClear) begin
            shiftWord <= '0;
        end else if (!link.chipSelectLow) begin
            shiftWord <= {shiftWord[WORD_BITS-2:0], link.mosi};
        end
    end

    // Select synchroniser
    always_ff @(posedge clock) begin
        if (!resetn) begin
            csSync1 <= 1'b1;
            csSync2 <= 1'b1;
        end else begin
            csSync1 <= link.chipSelectLow;
            csSync2 <= csSync1;
        end
    end

    // Previous synchronised select for edge detect
    always_ff @(posedge clock) begin
        if (!resetn) begin
            csPrev <= 1'b1;
        end else begin
            csPrev <= csSync2;
        end
    end

    // Override synchroniser
    always_ff @(posedge clock) begin
        if (!resetn) begin
            overrideSync1 <= 1'b0;
            overrideSync2 <= 1'b0;
        end else begin
            overrideSync1 <= firstOutputOverrideInput;
            overrideSync2 <= overrideSync1;
        end
    end

    // Frame end and word check; link state is still while select is high
    always_comb begin
        frameEnd = csSync2 && !csPrev;
        wordGood = (edgeCount == COUNT_WORD);
    end

    // Output control register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            outputSwitchControl <= OUTPUT_RESET;
        end else if (frameEnd && wordGood) begin
            outputSwitchControl <= shiftWord;
        end
    end

    // Load and discard pulses
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wordLoaded <= 1'b0;
            wordDiscarded <= 1'b0;
        end else begin
            wordLoaded <= frameEnd && wordGood;
            wordDiscarded <= frameEnd && !wordGood;
        end
    end

    // Tallies of loaded and discarded words
    always_ff @(posedge clock) begin
        if (!resetn) begin
            loadedTally <= '0;
        end else if (frameEnd && wordGood) begin
            loadedTally <= loadedTally + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            discardedTally <= '0;
        end else if (frameEnd && !wordGood) begin
            discardedTally <= discardedTally + 8'h01;
        end
    end

    // Driver levels, all eight change together
    always_comb begin
        next_lowSideDriverOutput = outputSwitchControl;
        next_lowSideDriverOutput[0] = outputSwitchControl[0] | overrideSync2;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            lowSideDriverOutput <= OUTPUT_RESET;
        end else begin
            lowSideDriverOutput <= next_lowSideDriverOutput;
        end
    end
endmodule : slo_device

// ==== core/slo_host.sv ====
// Serial controller: Avalon-MM registers, link clock divider, word sender
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module slo_host #(
    parameter int HALF = slo_pkg::HALF_CYCLES,
    parameter int REFRESH = slo_pkg::REFRESH_CYCLES
) (
    slo_link_if.host link,
    input wire logic clock,
    input wire logic resetn,
    input wire logic [slo_pkg::ADDR_BITS-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic transferBusy
);
    import slo_pkg::*;

    slo_state_type state;
    logic [TIMER_BITS-1:0] timer;
    logic [TIMER_BITS-1:0] refreshTimer;
    logic [COUNT_BITS-1:0] bitsLeft;
    logic [WORD_BITS-1:0] dataWord;
    logic [WORD_BITS-1:0] shiftOut;
    logic [TALLY_BITS-1:0] sentTally;
    logic refreshEnable;
    logic pendingStart;
    logic refreshDue;
    logic takeWrite;
    logic [31:0] readMux;

    localparam logic [TIMER_BITS-1:0] T_ONE = 12'h001;
    localparam logic [TIMER_BITS-1:0] T_LEAD = TIMER_BITS'(LEAD_CYCLES - 1);
    localparam logic [TIMER_BITS-1:0] T_HALF = TIMER_BITS'(HALF - 1);
    localparam logic [TIMER_BITS-1:0] T_TAIL = TIMER_BITS'(TAIL_CYCLES - 1);
    localparam int GAP_ALL = (GAP_CYCLES > DEVICE_SETTLE_CYCLES) ? GAP_CYCLES
        : DEVICE_SETTLE_CYCLES;
    localparam logic [TIMER_BITS-1:0] T_GAP = TIMER_BITS'(GAP_ALL - 1);
    localparam logic [TIMER_BITS-1:0] T_REFRESH = TIMER_BITS'(REFRESH - 1);

    // Bus handshake, one wait cycle per access
    always_ff @(posedge clock) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
            readdata <= '0;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= read ? readMux : 32'h00000000;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_comb begin
        takeWrite = write && !waitrequest;
        readMux = 32'h00000000;
        case (address)
            ADDR_DATA: readMux[WORD_BITS-1:0] = dataWord;
            ADDR_CTRL: readMux[CTRL_REFRESH_BIT] = refreshEnable;
            ADDR_STATUS: begin
                readMux[STATUS_BUSY_BIT] = transferBusy;
                readMux[STATUS_PENDING_BIT] = pendingStart;
                readMux[STATUS_TALLY_LSB +: TALLY_BITS] = sentTally;
            end
            default: readMux = 32'h00000000;
        endcase
    end

    // Word and control registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            dataWord <= OUTPUT_RESET;
            refreshEnable <= 1'b0;
        end else if (takeWrite && address == ADDR_DATA) begin
            dataWord <= writedata[WORD_BITS-1:0];
        end else if (takeWrite && address == ADDR_CTRL) begin
            refreshEnable <= writedata[CTRL_REFRESH_BIT];
        end
    end

    // Refresh period timer
    always_ff @(posedge clock) begin
        if (!resetn || !refreshEnable || refreshTimer == '0) begin
            refreshTimer <= T_REFRESH;
        end else begin
            refreshTimer <= refreshTimer - T_ONE;
        end
    end

    assign refreshDue = refreshEnable && refreshTimer == '0;

    // Start request; a new request wins over the take
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pendingStart <= 1'b0;
        end else if ((takeWrite && address == ADDR_DATA) || refreshDue) begin
            pendingStart <= 1'b1;
        end else if (state == ST_IDLE) begin
            pendingStart <= 1'b0;
        end
    end

    // Link sequencer
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= ST_IDLE;
            timer <= '0;
            bitsLeft <= '0;
            shiftOut <= '0;
            sentTally <= '0;
            transferBusy <= 1'b0;
            link.sclk <= 1'b0;
            link.chipSelectLow <= 1'b1;
            link.mosi <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    link.sclk <= 1'b0;
                    if (pendingStart) begin
                        link.chipSelectLow <= 1'b0;
                        link.mosi <= dataWord[WORD_BITS-1];
                        shiftOut <= dataWord;
                        bitsLeft <= COUNT_WORD;
                        timer <= T_LEAD;
                        transferBusy <= 1'b1;
                        state <= ST_LEAD;
                    end
                end
                ST_LEAD, ST_LOW: begin
                    if (timer == '0) begin
                        link.sclk <= 1'b1;
                        timer <= T_HALF;
                        state <= ST_HIGH;
                    end else begin
                        timer <= timer - T_ONE;
                    end
                end
                ST_HIGH: begin
                    if (timer == '0) begin
                        link.sclk <= 1'b0;
                        bitsLeft <= bitsLeft - COUNT_ONE;
                        if (bitsLeft == COUNT_ONE) begin
                            timer <= T_TAIL;
                            state <= ST_TAIL;
                        end else begin
                            shiftOut <= {shiftOut[WORD_BITS-2:0], 1'b0};
                            link.mosi <= shiftOut[WORD_BITS-2];
                            timer <= T_HALF;
                            state <= ST_LOW;
                        end
                    end else begin
                        timer <= timer - T_ONE;
                    end
                end
                ST_TAIL: begin
                    if (timer == '0) begin
                        link.chipSelectLow <= 1'b1;
                        sentTally <= sentTally + 8'h01;
                        timer <= T_GAP;
                        state <= ST_GAP;
                    end else begin
                        timer <= timer - T_ONE;
                    end
                end
                ST_GAP: begin
                    if (timer == '0) begin
                        transferBusy <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        timer <= timer - T_ONE;
                    end
                end
                default: begin
                    link.sclk <= 1'b0;
                    link.chipSelectLow <= 1'b1;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : slo_host

// ==== tb/slo_link_props.sv ====
// Concurrent checks on the serial link wires
`timescale 1ns/1ps
module slo_link_props #(
    parameter int HALF = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic chipSelectLow,
    input wire logic mosi
);
    logic sclkLast;
    logic [4:0] edgeCount;
    logic [3:0] highCount;
    logic [3:0] lowCount;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    always_ff @(posedge clock) begin
        sclkLast <= sclk;
    end
    always_ff @(posedge clock) begin
        if (!resetn || chipSelectLow) begin
            edgeCount <= 5'h00;
        end else if (sclk && !sclkLast) begin
            edgeCount <= edgeCount + 5'h01;
        end
    end
    always_ff @(posedge clock) begin
        highCount <= sclk ? highCount + 4'h1 : 4'h0;
    end
    always_ff @(posedge clock) begin
        lowCount <= (sclk || chipSelectLow) ? 4'h0 : lowCount + 4'h1;
    end
    chk_idle_clock_low: assert property (chipSelectLow |-> !sclk)
        else $error("serial clock moved while select high");
    chk_eight_rises: assert property ($rose(chipSelectLow) |-> edgeCount == 5'h08)
        else $error("frame did not carry eight clock rises");
    chk_high_width: assert property ($fell(sclk) |-> highCount == HALF)
        else $error("serial clock high phase has wrong length");
    chk_low_width: assert property ($rose(sclk) && edgeCount != 0 |-> lowCount == HALF)
        else $error("serial clock low phase has wrong length");
    chk_data_stable: assert property (sclk |-> $stable(mosi))
        else $error("data changed while serial clock high");
    chk_lead_select: assert property ($fell(chipSelectLow) |-> !sclk && $past(sclk) == 1'b0)
        else $error("clock not low when select fell");
    chk_tail_select: assert property ($rose(chipSelectLow) |-> $past(sclk) == 1'b0)
        else $error("select rose without a low tail");
    chk_word_gap: assert property ($rose(chipSelectLow) |-> chipSelectLow [*4])
        else $error("gap between words too short");
    chk_frame_bounded: assert property ($fell(chipSelectLow) |-> ##[1:80] $rose(chipSelectLow))
        else $error("frame did not end in time");
    cover property ($rose(chipSelectLow));
    cover property ($fell(chipSelectLow) ##1 sclk);
    cover property (sclk && mosi);
endmodule : slo_link_props

// ==== tb/serial_low_side_output_control_test.sv ====
// Testbench joining controller and output device, plus a bench-driven device
`timescale 1ns/1ps
module serial_low_side_output_control_test;
    import slo_pkg::*;
    localparam int HALF_SIM = 2;
    typedef struct packed { logic [7:0] data; logic ovr; } slo_row_type;
    slo_row_type rows [7] = '{'{8'hA5, 1'b0}, '{8'h5A, 1'b1}, '{8'hFF, 1'b0}, '{8'h01, 1'b0},
        '{8'h80, 1'b1}, '{8'h00, 1'b1}, '{8'h7E, 1'b0}};
    logic clock = 1'b0;
    logic devClock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] q;
    logic waitrequest;
    logic ovr = 1'b0;
    logic [7:0] drv, ctl, tally, ctlB, discB, tallyB, expFrames;
    logic [7:0] wireWord = 8'h00;
    logic loadPulse, discPulse, discPulseB;
    logic [7:0] disc;
    logic [7:0] loadCount = 8'h00;
    logic [7:0] discCountB = 8'h00;
    int numErrors = 0;
    int nChecks = 0;
    slo_link_if link();
    slo_link_if linkB();
    always #50 clock = ~clock;
    always #45 devClock = ~devClock;
    slo_host #(.HALF(HALF_SIM), .REFRESH(50)) i_slo_host (.link(link.host), .clock(clock),
        .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .transferBusy());
    slo_device i_slo_device (.link(link.device), .clock(devClock), .resetn(resetn),
        .firstOutputOverrideInput(ovr), .lowSideDriverOutput(drv), .outputSwitchControl(ctl),
        .wordLoaded(loadPulse), .wordDiscarded(discPulse), .loadedTally(tally),
        .discardedTally(disc));
    slo_device i_slo_device_b (.link(linkB.device), .clock(devClock), .resetn(resetn),
        .firstOutputOverrideInput(1'b0), .lowSideDriverOutput(), .outputSwitchControl(ctlB),
        .wordLoaded(), .wordDiscarded(discPulseB), .loadedTally(tallyB),
        .discardedTally(discB));
    slo_link_props #(.HALF(HALF_SIM)) i_slo_link_props (.clock(clock), .resetn(resetn),
        .sclk(link.sclk), .chipSelectLow(link.chipSelectLow), .mosi(link.mosi));
    initial begin
        linkB.sclk = 1'b0;
        linkB.chipSelectLow = 1'b1;
        linkB.mosi = 1'b0;
    end
    // Independent counts of the load and discard pulses
    always @(posedge devClock) begin
        if (loadPulse === 1'b1) loadCount <= loadCount + 8'h01;
        if (discPulseB === 1'b1) discCountB <= discCountB + 8'h01;
    end
    always @(posedge link.sclk) begin
        if (link.chipSelectLow === 1'b0) wireWord <= {wireWord[6:0], link.mosi};
    end
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32
    task automatic complete_run;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) numErrors++;
        @(posedge clock);
    endtask : av
    task automatic waitIdle;
        int n;
        n = 0;
        do begin
            av(ADDR_STATUS, 1'b0, 32'h0);
            n++;
        end while (q[1:0] !== 2'b00 && n < 200);
        if (n >= 200) numErrors++;
        repeat (8) @(posedge clock);
    endtask : waitIdle
    task automatic sendRaw(input int nbits, input logic [15:0] bits);
        linkB.chipSelectLow <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            @(posedge clock) linkB.mosi <= bits[nbits-1-i];
            @(posedge clock) linkB.sclk <= 1'b1;
            @(posedge clock) linkB.sclk <= 1'b0;
        end
        @(posedge clock) linkB.chipSelectLow <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clock) linkB.mosi <= ~linkB.mosi;
        end
    endtask : sendRaw
    initial begin
        #3000000;
        numErrors++;
        complete_run();
    end
    initial begin
        expFrames = 8'h00;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check8(ctl, OUTPUT_RESET);
        check8(drv, OUTPUT_RESET);
        av(ADDR_STATUS, 1'b0, 32'h0);
        check32(q, 32'h0);
        for (int i = 0; i < 7; i++) begin
            ovr <= rows[i].ovr;
            av(ADDR_DATA, 1'b1, {24'h0, rows[i].data});
            expFrames++;
            waitIdle();
            check8(wireWord, rows[i].data);
            check8(ctl, rows[i].data);
            check8(drv, rows[i].data | {7'h0, rows[i].ovr});
            check8(tally, expFrames);
            av(ADDR_DATA, 1'b0, 32'h0);
            check32(q, {24'h0, rows[i].data});
            av(ADDR_STATUS, 1'b0, 32'h0);
            check32(q, {16'h0, expFrames, 8'h00});
        end
        ovr <= 1'b0;
        av(4'hC, 1'b1, 32'hFF);
        av(4'hC, 1'b0, 32'h0);
        check32(q, 32'h0);
        av(ADDR_DATA, 1'b1, 32'h11);
        av(ADDR_DATA, 1'b1, 32'h96);
        expFrames += 8'h02;
        waitIdle();
        check8(ctl, 8'h96);
        check8(tally, expFrames);
        ovr <= 1'b1;
        repeat (4) @(posedge clock);
        check8(drv, 8'h97);
        ovr <= 1'b0;
        repeat (4) @(posedge clock);
        check8(drv, 8'h96);
        sendRaw(8, 16'h003C);
        check8(ctlB, 8'h3C);
        sendRaw(7, 16'h0055);
        check8(ctlB, 8'h3C);
        sendRaw(9, 16'h01FF);
        check8(ctlB, 8'h3C);
        check8(discB, 8'h02);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock) linkB.sclk <= ~linkB.sclk;
            linkB.mosi <= ~linkB.mosi;
        end
        sendRaw(8, 16'h00C3);
        check8(ctlB, 8'hC3);
        check8(tallyB, 8'h02);
        av(ADDR_CTRL, 1'b1, 32'h1);
        repeat (300) @(posedge clock);
        av(ADDR_CTRL, 1'b1, 32'h0);
        waitIdle();
        check8({7'h0, (tally - expFrames) >= 8'h04}, 8'h01);
        check8(ctl, 8'h96);
        check8(loadCount, tally);
        check8(disc, 8'h00);
        check8(discCountB, discB);
        // Reset in mid-run clears the register and the drivers
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check8(ctl, OUTPUT_RESET);
        check8(drv, OUTPUT_RESET);
        check8(tally, 8'h00);
        av(ADDR_STATUS, 1'b0, 32'h0);
        check32(q, 32'h0);
        complete_run();
    end
endmodule : serial_low_side_output_control_test
